// ### txfp_pkg.sv
// Constants and types for the transmit FIFO and status path
package txfp_pkg;
  localparam int DF_AW  = 9;
  localparam int MIL_AW = 9;
  localparam int SF_AW  = 4;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STAT     = 8'h04;
  localparam logic [7:0] REG_TXS_POP  = 8'h08;
  localparam logic [7:0] REG_TXS_PEEK = 8'h0c;
  localparam int CTRL_SDO      = 0;
  localparam int CTRL_DEFCHK   = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int STAT_TXE      = 0;
  localparam int STAT_SUSP     = 1;
  localparam int STAT_USED_LSB = 8;
  localparam int A_SIZE_MSB = 10;
  localparam int A_LS       = 12;
  localparam int A_FS       = 13;
  localparam int A_OFS_LSB  = 16;
  localparam int A_ALN_LSB  = 24;
  localparam int B_LEN_MSB  = 10;
  localparam int B_TAG_LSB  = 16;
  localparam int ST_ES      = 15;
  localparam int ST_EXDEF   = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       loss_carrier;
    logic       no_carrier;
    logic       late_col;
    logic       excess_col;
    logic [3:0] col_count;
    logic       excess_deferral;
    logic       deferred;
  } txfp_res_t;

  typedef struct packed {
    logic [15:0] tag;
    logic        last;
    logic [3:0]  be;
    logic [31:0] data;
  } txfp_mil_t;

  typedef enum logic [1:0] {H_CMDA = 2'h0, H_CMDB = 2'h1, H_BODY = 2'h3} txfp_hst_t;
  typedef enum logic [1:0] {U_CMDA = 2'h0, U_CMDB = 2'h1, U_DATA = 2'h3} txfp_unl_t;

  // Words holding payload plus sub-word start filler
  function automatic logic [9:0] txfp_words(input logic [1:0] lo, input logic [10:0] sz);
    logic [11:0] t;
    t = 12'(lo) + 12'(sz) + 12'h3;
    return t[11:2];
  endfunction

  // End alignment in words, minus one
  function automatic logic [3:0] txfp_alnmask(input logic [1:0] c);
    case (c)
      2'h1:    return 4'h3;
      2'h2:    return 4'h7;
      default: return 4'h0;
    endcase
  endfunction
endpackage

// ### txfp_top.sv
// Transmit data FIFO, store-and-forward MAC FIFO and TX status path
// Functional notes
// - MAC-side FIFO is store-and-forward; payload words and the end marker of a zero-word last buffer use space.
// - Whole-word offset and padding stripped; command words removed before MAC-side FIFO.
// - First command word of every buffer is stored in the data FIFO.
// - Second command word is stored only when first-segment flag is set.
// - Whole leading filler words dropped; sub-word leading bytes kept with payload.
// - Whole trailing padding words dropped; sub-word trailing remainder kept.
// - One status word per transmitted packet into the status FIFO.
// - Without discard option, transmission suspends while status FIFO is full.
// - With discard option, keep sending; on overrun used count reads zero, no writes.
// - With discard option, status overrun does not raise the error flag.
// - Packet tag from second command word goes to status bits 31:16.
// - Status bit 15 is OR of bits 11,10,9,8,2,1; reserved bits zero.
// - Bit 11 loss of carrier, bit 10 no carrier.
// - Bit 9 late collision after the 64-byte window.
// - Bit 8 abort after 16 collisions.
// - Bits 6:3 collision count, invalid when bit 8 set.
// - Bit 2 excessive deferral, only when deferral check is enabled.
// - Bit 0 set when the packet was deferred.
// - Host data arrives as 16-bit pairs, assembled into 32-bit words.
// - Error flag on second command word mismatch or packet length mismatch.
// - Error flag on data FIFO overrun, or status overrun without discard option.
`timescale 1ns/1ps
module txfp_top import txfp_pkg::*; (
  // Clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_B_I,
  // AXI4-Lite slave
  input  wire logic [7:0]  AXI_AWADDR_I,
  input  wire logic        AXI_AWVALID_I,
  output logic             AXI_AWREADY_O,
  input  wire logic [31:0] AXI_WDATA_I,
  input  wire logic [3:0]  AXI_WSTRB_I,
  input  wire logic        AXI_WVALID_I,
  output logic             AXI_WREADY_O,
  output logic [1:0]       AXI_BRESP_O,
  output logic             AXI_BVALID_O,
  input  wire logic        AXI_BREADY_I,
  input  wire logic [7:0]  AXI_ARADDR_I,
  input  wire logic        AXI_ARVALID_I,
  output logic             AXI_ARREADY_O,
  output logic [31:0]      AXI_RDATA_O,
  output logic [1:0]       AXI_RRESP_O,
  output logic             AXI_RVALID_O,
  input  wire logic        AXI_RREADY_I,
  // Host 16-bit transmit write port
  input  wire logic        HOST_WR_I,
  input  wire logic [15:0] HOST_DATA_I,
  // MAC side
  output logic [31:0]      MAC_DATA_O,
  output logic [3:0]       MAC_BE_O,
  output logic             MAC_LAST_O,
  output logic             MAC_VALID_O,
  input  wire logic        MAC_READY_I,
  input  wire logic        MAC_DONE_I,
  input  wire txfp_res_t   MAC_RES_I,
  // Error flag
  output logic             TXE_O
);

  logic [1:0]  ctrl_r;
  logic        txe_r;
  logic        sdo;
  assign sdo = ctrl_r[CTRL_SDO];

  // Host half-word pairing, low half first
  logic        half_r;
  logic [15:0] lo_r;
  logic        hw_vld;
  logic [31:0] hw;
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      half_r <= 1'b0;
      lo_r   <= 16'h0;
    end else if (HOST_WR_I) begin
      half_r <= ~half_r;
      if (!half_r) begin
        lo_r <= HOST_DATA_I;
      end
    end
  end
  assign hw_vld = HOST_WR_I & half_r;
  assign hw     = {HOST_DATA_I, lo_r};

  // Host-side buffer parser
  txfp_hst_t   hst_r;
  logic [31:0] a_r;
  logic [31:0] b_r;
  logic [2:0]  ofs_r;
  logic [9:0]  dat_r;
  logic [3:0]  end_r;
  logic [10:0] cum_r;
  logic [9:0]  nw;
  logic [9:0]  tot;
  logic [3:0]  nend;
  logic [10:0] len_sum;
  logic [10:0] rem;
  logic        df_wr;
  logic        e_bmis;
  logic        e_len;
  assign nw      = txfp_words(a_r[A_OFS_LSB+:2], a_r[A_SIZE_MSB:0]);
  assign tot     = nw + 10'(a_r[A_OFS_LSB+2+:3]);
  assign nend    = 4'(~tot + 10'h1) & txfp_alnmask(a_r[A_ALN_LSB+:2]);
  assign len_sum = (a_r[A_FS] ? 11'h0 : cum_r) + a_r[A_SIZE_MSB:0];
  assign rem     = 11'(ofs_r) + 11'(dat_r) + 11'(end_r);

  always_comb begin
    df_wr  = 1'b0;
    e_bmis = 1'b0;
    e_len  = 1'b0;
    if (hw_vld) begin
      unique case (hst_r)
        H_CMDA: df_wr = 1'b1;
        H_CMDB: begin
          df_wr  = a_r[A_FS];
          e_bmis = !a_r[A_FS] && (hw != b_r);
          e_len  = a_r[A_LS] && (len_sum != hw[B_LEN_MSB:0]);
        end
        H_BODY: df_wr = (ofs_r == 3'h0) && (dat_r != 10'h0);
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      hst_r <= H_CMDA;
      a_r   <= 32'h0;
      b_r   <= 32'h0;
      ofs_r <= 3'h0;
      dat_r <= 10'h0;
      end_r <= 4'h0;
      cum_r <= 11'h0;
    end else if (hw_vld) begin
      unique case (hst_r)
        H_CMDA: begin
          a_r   <= hw;
          hst_r <= H_CMDB;
        end
        H_CMDB: begin
          b_r   <= hw;
          cum_r <= len_sum;
          ofs_r <= a_r[A_OFS_LSB+2+:3];
          dat_r <= nw;
          end_r <= nend;
          hst_r <= (tot == 10'h0) ? H_CMDA : H_BODY;
        end
        H_BODY: begin
          if (ofs_r != 3'h0) begin
            ofs_r <= ofs_r - 3'h1;
          end else if (dat_r != 10'h0) begin
            dat_r <= dat_r - 10'h1;
          end else begin
            end_r <= end_r - 4'h1;
          end
          if (rem == 11'h1) begin
            hst_r <= H_CMDA;
          end
        end
      endcase
    end
  end

  // TX data FIFO
  logic [31:0]     df_mem [2**DF_AW];
  logic [DF_AW:0]  df_wp;
  logic [DF_AW:0]  df_rp;
  logic            df_full;
  logic            df_empty;
  logic            df_pop;
  logic            df_ovr;
  logic [31:0]     df_q;
  assign df_empty = df_wp == df_rp;
  assign df_full  = (df_wp[DF_AW] != df_rp[DF_AW]) && (df_wp[DF_AW-1:0] == df_rp[DF_AW-1:0]);
  assign df_ovr   = df_wr && df_full;
  assign df_q     = df_mem[df_rp[DF_AW-1:0]];

  always_ff @(posedge SYS_CLK_I) begin
    if (df_wr && !df_full) begin
      df_mem[df_wp[DF_AW-1:0]] <= hw;
    end
  end
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      df_wp <= '0;
      df_rp <= '0;
    end else begin
      if (df_wr && !df_full) begin
        df_wp <= df_wp + (DF_AW+1)'(1);
      end
      if (df_pop) begin
        df_rp <= df_rp + (DF_AW+1)'(1);
      end
    end
  end

  // Unload into MAC-side FIFO, commands stripped here
  txfp_unl_t   unl_r;
  logic [31:0] ua_r;
  logic [15:0] utag_r;
  logic [9:0]  ucnt_r;
  logic        ufirst_r;
  logic [1:0]  u_lo;
  logic [1:0]  u_eb;
  logic [3:0]  u_be;
  logic        mil_push;
  logic        mil_full;
  txfp_mil_t   mil_wd;
  assign u_lo = ua_r[A_OFS_LSB+:2];
  assign u_eb = 2'(u_lo + ua_r[1:0] + 2'h3);
  assign u_be = (ufirst_r ? (4'hf << u_lo) : 4'hf) & ((ucnt_r == 10'h1) ? (4'hf >> (2'h3 - u_eb)) : 4'hf);

  always_comb begin
    df_pop      = 1'b0;
    mil_push    = 1'b0;
    mil_wd.tag  = utag_r;
    mil_wd.last = ua_r[A_LS] && (ucnt_r <= 10'h1);
    mil_wd.be   = (ucnt_r == 10'h0) ? 4'h0 : u_be;
    mil_wd.data = df_q;
    unique case (unl_r)
      U_CMDA, U_CMDB: df_pop = !df_empty;
      U_DATA: begin
        if (ucnt_r != 10'h0) begin
          df_pop   = !df_empty && !mil_full;
          mil_push = df_pop;
        end else begin
          mil_push = ua_r[A_LS] && !mil_full;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      unl_r    <= U_CMDA;
      ua_r     <= 32'h0;
      utag_r   <= 16'h0;
      ucnt_r   <= 10'h0;
      ufirst_r <= 1'b0;
    end else begin
      unique case (unl_r)
        U_CMDA: if (df_pop) begin
          ua_r     <= df_q;
          ucnt_r   <= txfp_words(df_q[A_OFS_LSB+:2], df_q[A_SIZE_MSB:0]);
          ufirst_r <= 1'b1;
          unl_r    <= df_q[A_FS] ? U_CMDB : U_DATA;
        end
        U_CMDB: if (df_pop) begin
          utag_r <= df_q[B_TAG_LSB+:16];
          unl_r  <= U_DATA;
        end
        U_DATA: begin
          if (df_pop) begin
            ucnt_r   <= ucnt_r - 10'h1;
            ufirst_r <= 1'b0;
            if (ucnt_r == 10'h1) begin
              unl_r <= U_CMDA;
            end
          end else if (ucnt_r == 10'h0 && (mil_push || !ua_r[A_LS])) begin
            unl_r <= U_CMDA;
          end
        end
      endcase
    end
  end

  // MAC-side FIFO, store and forward
  txfp_mil_t       mil_mem [2**MIL_AW];
  logic [MIL_AW:0] mil_wp;
  logic [MIL_AW:0] mil_rp;
  logic [MIL_AW:0] mil_pkts_r;
  logic            mil_empty;
  logic            mil_pop;
  logic            suspend;
  logic            in_pkt_r;
  txfp_mil_t       mil_q;
  txfp_mil_t       out_r;
  logic            out_vld_r;
  logic [15:0]     sts_tag_r;
  logic            sf_full;
  assign mil_empty = mil_wp == mil_rp;
  assign mil_full  = (mil_wp[MIL_AW] != mil_rp[MIL_AW]) && (mil_wp[MIL_AW-1:0] == mil_rp[MIL_AW-1:0]);
  assign mil_q     = mil_mem[mil_rp[MIL_AW-1:0]];
  assign suspend   = sf_full && !sdo;
  // A packet starts only once whole; no mid-packet stall on status space
  assign mil_pop   = !mil_empty && (!out_vld_r || MAC_READY_I)
                     && (in_pkt_r || (mil_pkts_r != '0 && !suspend));

  always_ff @(posedge SYS_CLK_I) begin
    if (mil_push) begin
      mil_mem[mil_wp[MIL_AW-1:0]] <= mil_wd;
    end
  end
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mil_wp     <= '0;
      mil_rp     <= '0;
      mil_pkts_r <= '0;
    end else begin
      mil_wp     <= mil_wp + (MIL_AW+1)'(mil_push);
      mil_rp     <= mil_rp + (MIL_AW+1)'(mil_pop);
      mil_pkts_r <= mil_pkts_r + (MIL_AW+1)'(mil_push && mil_wd.last) - (MIL_AW+1)'(mil_pop && mil_q.last);
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      out_r     <= '0;
      out_vld_r <= 1'b0;
      in_pkt_r  <= 1'b0;
      sts_tag_r <= 16'h0;
    end else if (mil_pop) begin
      out_r     <= mil_q;
      out_vld_r <= 1'b1;
      in_pkt_r  <= !mil_q.last;
      if (mil_q.last) begin
        sts_tag_r <= mil_q.tag;
      end
    end else if (MAC_READY_I) begin
      out_vld_r <= 1'b0;
    end
  end
  assign MAC_DATA_O  = out_r.data;
  assign MAC_BE_O    = out_r.be;
  assign MAC_LAST_O  = out_r.last;
  assign MAC_VALID_O = out_vld_r;

  // TX status FIFO
  logic [31:0]    sf_mem [2**SF_AW];
  logic [SF_AW:0] sf_wp;
  logic [SF_AW:0] sf_rp;
  logic [SF_AW:0] sf_cnt;
  logic [SF_AW:0] used_vis;
  logic           sf_empty;
  logic           sf_push;
  logic           sf_pop;
  logic           sf_ovr;
  logic           hide_r;
  logic           exdef;
  logic           es;
  logic [31:0]    sf_wd;
  logic           ar_hs;
  logic [7:0]     ar_a;
  assign ar_a     = AXI_ARADDR_I;
  assign sf_cnt   = sf_wp - sf_rp;
  assign sf_empty = sf_wp == sf_rp;
  assign sf_full  = sf_cnt[SF_AW];
  assign sf_push  = MAC_DONE_I && !sf_full;
  assign sf_ovr   = MAC_DONE_I && sf_full;
  assign sf_pop   = ar_hs && (ar_a == REG_TXS_POP) && !sf_empty;
  assign used_vis = hide_r ? '0 : sf_cnt;
  assign exdef    = MAC_RES_I.excess_deferral && ctrl_r[CTRL_DEFCHK];
  assign es       = MAC_RES_I.loss_carrier | MAC_RES_I.no_carrier | MAC_RES_I.late_col
                    | MAC_RES_I.excess_col | exdef;
  assign sf_wd    = {sts_tag_r, es, 3'h0,
                     MAC_RES_I.loss_carrier, MAC_RES_I.no_carrier,
                     MAC_RES_I.late_col, MAC_RES_I.excess_col,
                     1'b0, MAC_RES_I.col_count,
                     exdef, 1'b0, MAC_RES_I.deferred};

  always_ff @(posedge SYS_CLK_I) begin
    if (sf_push) begin
      sf_mem[sf_wp[SF_AW-1:0]] <= sf_wd;
    end
  end
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sf_wp  <= '0;
      sf_rp  <= '0;
      hide_r <= 1'b0;
    end else begin
      sf_wp <= sf_wp + (SF_AW+1)'(sf_push);
      sf_rp <= sf_rp + (SF_AW+1)'(sf_pop);
      if (sf_ovr && sdo) begin
        hide_r <= 1'b1;
      end else if (sf_pop) begin
        hide_r <= 1'b0;
      end
    end
  end

  // AXI4-Lite write channel
  logic        awrdy_r;
  logic        wrdy_r;
  logic        bvld_r;
  logic [1:0]  bresp_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  awa_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  logic        wr_do;
  logic        txe_clr;
  assign wr_do   = aw_got_r && w_got_r && !bvld_r;
  assign txe_clr = wr_do && (awa_r == REG_STAT) && ws_r[0] && wd_r[STAT_TXE];

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      awrdy_r  <= 1'b1;
      wrdy_r   <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awa_r    <= 8'h0;
      wd_r     <= 32'h0;
      ws_r     <= 4'h0;
      bvld_r   <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else begin
      if (AXI_AWVALID_I && awrdy_r) begin
        awa_r    <= AXI_AWADDR_I;
        aw_got_r <= 1'b1;
        awrdy_r  <= 1'b0;
      end
      if (AXI_WVALID_I && wrdy_r) begin
        wd_r    <= AXI_WDATA_I;
        ws_r    <= AXI_WSTRB_I;
        w_got_r <= 1'b1;
        wrdy_r  <= 1'b0;
      end
      if (wr_do) begin
        bvld_r  <= 1'b1;
        bresp_r <= (awa_r[7:4] == 4'h0 && awa_r[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvld_r && AXI_BREADY_I) begin
        bvld_r   <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        awrdy_r  <= 1'b1;
        wrdy_r   <= 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_do && awa_r == REG_CTRL && ws_r[0]) begin
      ctrl_r <= wd_r[1:0];
    end
  end

  // Error flag, set wins over clear; transmission never waits on it
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      txe_r <= 1'b0;
    end else begin
      txe_r <= df_ovr | e_bmis | e_len | (sf_ovr && !sdo) | (txe_r & ~txe_clr);
    end
  end
  assign TXE_O = txe_r;

  // AXI4-Lite read channel
  logic        arrdy_r;
  logic        rvld_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] rd_val;
  assign ar_hs = AXI_ARVALID_I && arrdy_r;

  always_comb begin
    rd_val = 32'h0;
    case (ar_a)
      REG_CTRL: rd_val = 32'(ctrl_r);
      REG_STAT: begin
        rd_val[STAT_TXE]                  = txe_r;
        rd_val[STAT_SUSP]                 = suspend;
        rd_val[STAT_USED_LSB+:SF_AW+1]    = used_vis;
      end
      REG_TXS_POP, REG_TXS_PEEK: rd_val = sf_empty ? 32'h0 : sf_mem[sf_rp[SF_AW-1:0]];
      default: rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      arrdy_r <= 1'b1;
      rvld_r  <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (ar_hs) begin
      arrdy_r <= 1'b0;
      rvld_r  <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= (ar_a[7:4] == 4'h0 && ar_a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvld_r && AXI_RREADY_I) begin
      arrdy_r <= 1'b1;
      rvld_r  <= 1'b0;
    end
  end

  assign AXI_AWREADY_O = awrdy_r;
  assign AXI_WREADY_O  = wrdy_r;
  assign AXI_BVALID_O  = bvld_r;
  assign AXI_BRESP_O   = bresp_r;
  assign AXI_ARREADY_O = arrdy_r;
  assign AXI_RVALID_O  = rvld_r;
  assign AXI_RDATA_O   = rdata_r;
  assign AXI_RRESP_O   = rresp_r;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);

  property p_es;
    sf_push |-> sf_wd[ST_ES] == |{sf_wd[11:8], sf_wd[2:1]} && sf_wd[14:12] == 3'h0 && !sf_wd[7] && !sf_wd[1];
  endproperty
  a_es: assert property (p_es) else $error("status summary bit wrong");
  property p_tag;
    sf_push && out_r.last |-> sf_wd[31:16] == out_r.tag;
  endproperty
  a_tag: assert property (p_tag) else $error("status tag wrong");
  property p_susp;
    sf_full && !sdo && !in_pkt_r |-> !mil_pop;
  endproperty
  a_susp: assert property (p_susp) else $error("packet started while status full");
  property p_hide;
    sf_ovr && sdo && !sf_pop |=> used_vis == '0 && sf_wp == $past(sf_wp);
  endproperty
  a_hide: assert property (p_hide) else $error("overrun not hidden");
  property p_noerr;
    sf_ovr && sdo && !txe_r && !df_ovr && !e_bmis && !e_len && !txe_clr |=> !txe_r;
  endproperty
  a_noerr: assert property (p_noerr) else $error("error on discarded overrun");
  property p_dfovr;
    df_ovr |=> txe_r;
  endproperty
  a_dfovr: assert property (p_dfovr) else $error("data overrun not flagged");
  property p_cmdb;
    hw_vld && hst_r == H_CMDB && !a_r[A_FS] |-> !df_wr;
  endproperty
  a_cmdb: assert property (p_cmdb) else $error("second command stored off first segment");
  property p_strip;
    hw_vld && hst_r == H_BODY && (ofs_r != 3'h0 || dat_r == 10'h0) |=> df_wp == $past(df_wp);
  endproperty
  a_strip: assert property (p_strip) else $error("whole filler word stored");
  property p_exdef;
    sf_push && !ctrl_r[CTRL_DEFCHK] |-> !sf_wd[ST_EXDEF];
  endproperty
  a_exdef: assert property (p_exdef) else $error("deferral bit without check");
  property p_cnt;
    sf_push && !sf_pop |=> sf_cnt == $past(sf_cnt) + 1'b1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("status count not advanced");

  c_pkt: cover property (out_vld_r && MAC_READY_I && out_r.last);
  c_hide: cover property (sf_ovr && sdo);
  c_txe: cover property (e_len || e_bmis);
endmodule

// ### txfp_host.sv
// Host CPU model writing transmit words as 16-bit halves
`timescale 1ns/1ps
module txfp_host (
  // Clock
  input  wire logic   clk_i,
  // Host write port
  output logic        wr_o,
  output logic [15:0] data_o
);
  initial begin
    wr_o   = 1'b0;
    data_o = 16'h0000;
  end
  // Callers send 4-, 5- and 2047-byte buffers, enough to fill the FIFOs and the status count
  task automatic put(input logic [31:0] w);
    @(posedge clk_i);
    wr_o   <= 1'b1;
    data_o <= w[15:0];
    @(posedge clk_i);
    data_o <= w[31:16];
    @(posedge clk_i);
    wr_o   <= 1'b0;
    // Released bus shows inverted data, never a stale copy
    data_o <= ~w[31:16];
  endtask
endmodule

// ### txfp_top_tb_top.sv
// Testbench for the transmit FIFO and status path
`timescale 1ns/1ps
module txfp_top_tb_top import txfp_pkg::*;;
  typedef struct packed {logic [15:0] tag; logic dc; txfp_res_t res;} txfp_row_t;
  logic        clk, rst_b, awv, wv, bry, arv, rry, mrdy, mdone, hw;
  logic        awry, wry, bv, arry, rv, mv, ml, transmitter_error_flag;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdd, md, rdv;
  logic [15:0] hd;
  logic [1:0]  br, rr, rsp;
  logic [3:0]  mbe, ws;
  txfp_res_t   mres;
  logic [31:0] gd[$];
  logic [3:0]  gbe[$];
  logic        gl[$];
  int          failures, tests_run;
  txfp_row_t   rows[6] = '{'{16'h1111, 1'b0, 10'h000}, '{16'h2222, 1'b0, 10'h201}, '{16'h3333, 1'b1, 10'h002},
                           '{16'h4444, 1'b0, 10'h002}, '{16'h5555, 1'b0, 10'h07c}, '{16'h6666, 1'b0, 10'h1a4}};

  txfp_host host (.clk_i(clk), .wr_o(hw), .data_o(hd));
  txfp_top dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .AXI_AWADDR_I(awa), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awry),
    .AXI_WDATA_I(wd), .AXI_WSTRB_I(ws), .AXI_WVALID_I(wv), .AXI_WREADY_O(wry), .AXI_BRESP_O(br),
    .AXI_BVALID_O(bv), .AXI_BREADY_I(bry), .AXI_ARADDR_I(ara), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arry),
    .AXI_RDATA_O(rdd), .AXI_RRESP_O(rr), .AXI_RVALID_O(rv), .AXI_RREADY_I(rry), .HOST_WR_I(hw),
    .HOST_DATA_I(hd), .MAC_DATA_O(md), .MAC_BE_O(mbe), .MAC_LAST_O(ml), .MAC_VALID_O(mv),
    .MAC_READY_I(mrdy), .MAC_DONE_I(mdone), .MAC_RES_I(mres), .TXE_O(transmitter_error_flag));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Ready toggles so the MAC side stalls every other cycle
  always @(posedge clk) begin
    mrdy <= ~mrdy;
    if (mv && mrdy) begin
      gd.push_back(md);
      gbe.push_back(mbe);
      gl.push_back(ml);
    end
  end

  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic tmo(input string m);
    failures++;
    $display("MISMATCH %0t timeout %s", $time, m);
    close_out();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awa <= a;
    wd  <= v;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    for (int n = 0; n <= 50; n++) begin
      if (n == 50) tmo("b");
      @(posedge clk);
      if (awv && awry) awv <= 1'b0;
      if (wv && wry) wv <= 1'b0;
      if (bv) begin
        rsp = br;
        break;
      end
    end
    bry <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (int n = 0; n <= 50; n++) begin
      if (n == 50) tmo("r");
      @(posedge clk);
      if (arv && arry) arv <= 1'b0;
      if (rv) begin
        rdv = rdd;
        rsp = rr;
        break;
      end
    end
    rry <= 1'b0;
  endtask
  task automatic wt(input int n);
    for (int i = 0; i < 400 && gd.size() < n; i++) @(posedge clk);
    if (gd.size() < n) tmo("mac");
  endtask
  function automatic logic [31:0] est(input logic [15:0] t, input txfp_res_t r, input logic dc);
    logic ed;
    ed = r.excess_deferral & dc;
    return {t, r.loss_carrier | r.no_carrier | r.late_col | r.excess_col | ed, 3'h0, r.loss_carrier,
            r.no_carrier, r.late_col, r.excess_col, 1'b0, r.col_count, ed, 1'b0, r.deferred};
  endfunction
  // One buffer: offset 5, 5 bytes, 16-byte end alignment
  task automatic xmit(input logic [15:0] t, input logic [10:0] len, input txfp_res_t r, input bit hold);
    gd.delete();
    gbe.delete();
    gl.delete();
    host.put(32'h0105_3005);
    host.put({t, 5'h0, len});
    host.put(32'hdeadbeef);
    host.put(32'h33221100);
    host.put(32'hffff5544);
    host.put(32'hcafef00d);
    if (hold) begin
      repeat (80) @(posedge clk);
      chk(32'(gd.size()), 32'h0, "held");
      axr(REG_STAT);
      chk({rdv[STAT_SUSP], 3'h0, rdv[STAT_USED_LSB +: 5]}, 32'h110, "susp");
      axr(REG_TXS_POP);
    end
    wt(2);
    chk({8'h0, gd[0][31:8]}, 32'h332211, "head");
    chk({16'h0, gd[1][15:0]}, 32'h5544, "tail");
    chk({gbe[0], gbe[1], gl[0], gl[1]}, 32'h38d, "be");
    @(posedge clk);
    mdone <= 1'b1;
    mres  <= r;
    @(posedge clk);
    mdone <= 1'b0;
    @(posedge clk);
    chk(32'(gd.size()), 32'h2, "count");
  endtask

  initial begin
    {rst_b, awv, wv, bry, arv, rry, mrdy, mdone, awa, ara, wd, mres} = '0;
    ws        = 4'hf;
    failures  = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({awry, wry, arry, bv, rv, mv, transmitter_error_flag}, 32'h70, "rst");
    axr(REG_CTRL);
    chk(rdv, 32'(CTRL_RST), "ctrl");
    axr(8'h40);
    chk({rdv, rsp}, {32'h0, RESP_SLVERR}, "unmapped");
    axw(8'h40, 32'h3);
    chk(32'(rsp), 32'(RESP_SLVERR), "wunmapped");
    $display("Reset test done");
    foreach (rows[i]) begin
      axw(REG_CTRL, {30'h0, rows[i].dc, 1'b0});
      xmit(rows[i].tag, 11'h5, rows[i].res, 1'b0);
      axr(REG_STAT);
      chk(32'(rdv[STAT_USED_LSB +: 5]), 32'h1, "used");
      axr(REG_TXS_POP);
      chk(rdv, est(rows[i].tag, rows[i].res, rows[i].dc), "status");
      $display("Row %0d done", i);
    end
    axw(REG_CTRL, 32'h0);
    chk(32'(rsp), 32'(RESP_OKAY), "wok");
    for (int i = 0; i < 16; i++) xmit(16'(i), 11'h5, '0, 1'b0);
    xmit(16'h7777, 11'h5, '0, 1'b1);
    chk(32'(transmitter_error_flag), 32'h0, "txe");
    $display("Suspend test done");
    axw(REG_CTRL, 32'h1);
    xmit(16'h8888, 11'h5, '0, 1'b0);
    axr(REG_STAT);
    chk({transmitter_error_flag, rdv[STAT_TXE], rdv[STAT_USED_LSB +: 5]}, 32'h0, "overrun");
    for (int i = 0; i < 16; i++) axr(REG_TXS_POP);
    $display("Discard test done");
    xmit(16'h9999, 11'h6, '0, 1'b0);
    chk(32'(transmitter_error_flag), 32'h1, "len");
    axw(REG_STAT, 32'h1);
    chk(32'(transmitter_error_flag), 32'h0, "clear");
    gd.delete();
    gl.delete();
    host.put(32'h0000_2004);
    host.put({16'haaaa, 5'h0, 11'h8});
    host.put(32'h0403_0201);
    host.put(32'h0000_1004);
    host.put({16'hbbbb, 5'h0, 11'h8});
    host.put(32'h0807_0605);
    wt(2);
    chk(gd[1], 32'h0807_0605, "segment");
    chk(32'({gl[0], gl[1]}), 32'h1, "seglast");
    chk(32'(transmitter_error_flag), 32'h1, "bmis");
    ws <= 4'h0;
    axw(REG_STAT, 32'h1);
    chk(32'(transmitter_error_flag), 32'h1, "strobe");
    ws <= 4'hf;
    axw(REG_STAT, 32'h1);
    chk(32'(transmitter_error_flag), 32'h0, "reclear");
    $display("Error test done");
    // Open packet fills the MAC-side FIFO, then the data FIFO overruns
    for (int k = 0; k < 3; k++) begin
      host.put(32'h0000_27ff);
      host.put(32'h0);
      for (int i = 0; i < 512; i++) host.put(32'(i));
    end
    chk(32'(transmitter_error_flag), 32'h1, "dfovr");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({awry, wry, arry, bv, rv, mv, transmitter_error_flag}, 32'h70, "rst2");
    $display("Overrun and reset test done");
    close_out();
  end
endmodule
